// ===== asr_top.v
// Receive checks, baud generation, mute and parity of an async serial port.
// Assumes one 100 MHz clock and an Avalon-MM master with one access at a
// time; serial input is asynchronous to clk.
`timescale 1ns/1ps
`include "asr_map.vh"
module asr_top (
  input wire clk, // 100 MHz core clock
  input wire rstn, // Synchronous reset, active low
  input wire [3:0] avs_address, // Word index
  input wire avs_read, // Read strobe
  input wire avs_write, // Write strobe
  input wire [31:0] avs_writedata, // Write data
  input wire [3:0] avs_byteenable, // Byte lanes
  output reg [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall
  input wire serial_input_pin, // Serial data in
  input wire [8:0] tx_word, // Word from transmitter buffer
  output wire [8:0] tx_shift_word, // Word with parity applied
  output wire tx_tick, // Tx 16x sample tick
  output wire rx_irq // Receive interrupt request
);
  // Bus handshake: one wait cycle per access
  reg ack_r;
  always @(posedge clk) begin
    if (!rstn) ack_r <= 1'b0;
    else ack_r <= (avs_read | avs_write) & ~ack_r;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  wire rd_go = avs_read & ack_r;
  wire wr_go = avs_write & ack_r & avs_byteenable[0];

  reg [7:0] ctrl1_r, ctrl2_r, baud_r, rx_fine_r, tx_fine_r;
  reg [8:0] receive_buffer_r;
  reg receive_full_flag_r, noise_flag_r, framing_fault_flag_r;
  reg parity_fail_flag_r, overrun_r, idle_r, stat_seen_r, hidden_noise_r;
  wire m_bit = ctrl1_r[`ASR_C1_M];
  wire parity_enable = ctrl1_r[`ASR_C1_PCE];
  wire ps = ctrl1_r[`ASR_C1_PS];
  wire mute_request = ctrl2_r[`ASR_C2_RWU];

  // Baud: 16x tick = clk / (shared factor * 2^sel * fine), a fine of 0 counting as 1
  function [11:0] shared_divide_factor;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: shared_divide_factor = 12'h001;
        2'h1: shared_divide_factor = 12'h003;
        2'h2: shared_divide_factor = 12'h004;
        default: shared_divide_factor = 12'h00D;
      endcase
    end
  endfunction
  function [22:0] div_total;
    input [1:0] sp;
    input [2:0] ps2;
    input [7:0] fine;
    reg [22:0] f;
    begin
      f = {11'h000, shared_divide_factor(sp)} << ps2;
      div_total = (fine == 8'h00) ? f : f * {15'h0000, fine};
    end
  endfunction
  wire [22:0] rx_div = div_total(baud_r[7:6], baud_r[2:0], rx_fine_r);
  wire [22:0] tx_div = div_total(baud_r[7:6], baud_r[5:3], tx_fine_r);
  reg [22:0] rx_cnt_r, tx_cnt_r;
  wire rx_tick = (rx_cnt_r >= rx_div - 23'h000001);
  assign tx_tick = (tx_cnt_r >= tx_div - 23'h000001);
  // Separate counters for each direction
  always @(posedge clk) begin
    if (!rstn) begin
      rx_cnt_r <= 23'h000000;
      tx_cnt_r <= 23'h000000;
    end else begin
      rx_cnt_r <= rx_tick ? 23'h000000 : rx_cnt_r + 23'h000001;
      tx_cnt_r <= tx_tick ? 23'h000000 : tx_cnt_r + 23'h000001;
    end
  end

  // Transmit parity replaces the data msb
  wire tx_par = ps ^ (m_bit ? ^tx_word[7:0] : ^tx_word[6:0]);
  assign tx_shift_word = !parity_enable ? tx_word :
    (m_bit ? {tx_par, tx_word[7:0]} : {1'b0, tx_par, tx_word[6:0]});

  // Input synchroniser, three stages, change when 2nd and 3rd agree
  reg s1_r, s2_r, s3_r, rxd_r;
  always @(posedge clk) begin
    if (!rstn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      rxd_r <= 1'b1;
    end else begin
      s1_r <= serial_input_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) rxd_r <= s3_r;
    end
  end

  // Receiver state machine
  localparam ST_HUNT = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STOP = 2'h3;
  reg [1:0] st_r;
  reg [3:0] smp_r;
  reg [3:0] bit_r;
  reg [2:0] hist_r;
  reg [2:0] mid_r;
  reg edge_bad_r, fnoise_r, allone_r;
  reg [8:0] shift_r;
  wire majority = (mid_r[0] & mid_r[1]) | (mid_r[0] & mid_r[2]) |
    (mid_r[1] & mid_r[2]);
  wire mid_noisy = ~(mid_r[0] == mid_r[1] && mid_r[1] == mid_r[2]);
  wire [3:0] nbits = m_bit ? 4'h9 : 4'h8;
  wire [8:0] word = m_bit ? shift_r : {1'b0, shift_r[8:1]};
  wire rx_par_bad = parity_enable & (ps ^ (m_bit ? ^word[8:0] : ^word[7:0]));
  wire addr_msb = m_bit ? (parity_enable ? word[7] : word[8]) :
    (parity_enable ? word[6] : word[7]);
  reg evt_frame, evt_idle;
  reg frame_fe, frame_nf;
  // Sample and shift
  always @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_HUNT;
      smp_r <= 4'h0;
      bit_r <= 4'h0;
      hist_r <= 3'h0;
      mid_r <= 3'h0;
      edge_bad_r <= 1'b0;
      fnoise_r <= 1'b0;
      allone_r <= 1'b1;
      shift_r <= 9'h000;
      evt_frame <= 1'b0;
      evt_idle <= 1'b0;
      frame_fe <= 1'b0;
      frame_nf <= 1'b0;
    end else begin
      evt_frame <= 1'b0;
      evt_idle <= 1'b0;
      if (!ctrl2_r[`ASR_C2_RE]) begin
        st_r <= ST_HUNT;
        hist_r <= 3'h0;
      end else if (rx_tick) begin
        smp_r <= smp_r + 4'h1;
        if (smp_r >= 4'h7 && smp_r <= 4'h9)
          mid_r <= {rxd_r, mid_r[2:1]};
        case (st_r)
          ST_HUNT: begin
            hist_r <= {hist_r[1:0], rxd_r};
            if (hist_r == 3'h7 && !rxd_r) begin
              st_r <= ST_START;
              smp_r <= 4'h1;
              edge_bad_r <= 1'b0;
            end
          end
          ST_START: begin
            if ((smp_r == 4'h2 || smp_r == 4'h4 || smp_r == 4'h6) && rxd_r)
              edge_bad_r <= 1'b1;
            if (smp_r == 4'hA) begin
              if (mid_r != 3'h0) begin
                st_r <= ST_HUNT;
                hist_r <= 3'h0;
                fnoise_r <= 1'b1;
              end else begin
                fnoise_r <= fnoise_r | edge_bad_r;
                allone_r <= 1'b1;
              end
            end
            if (smp_r == 4'hF) begin
              st_r <= ST_DATA;
              bit_r <= 4'h0;
            end
          end
          ST_DATA: begin
            if (smp_r == 4'hA) begin
              shift_r <= {majority, shift_r[8:1]};
              allone_r <= allone_r & majority;
              if (mid_noisy) fnoise_r <= 1'b1;
            end
            if (smp_r == 4'hF) begin
              bit_r <= bit_r + 4'h1;
              if (bit_r == nbits - 4'h1) st_r <= ST_STOP;
            end
          end
          default: begin
            if (smp_r == 4'hA) begin
              frame_fe <= ~majority;
              frame_nf <= fnoise_r | mid_noisy;
              fnoise_r <= 1'b0;
              evt_idle <= allone_r & majority;
              evt_frame <= ~(allone_r & majority);
              st_r <= ST_HUNT;
              hist_r <= 3'h0;
            end
          end
        endcase
      end
    end
  end

  // Read of status arms the clear; read of data completes it
  wire rd_stat = rd_go && avs_address == `ASR_OFF_STATUS;
  wire rd_data = rd_go && avs_address == `ASR_OFF_DATA;
  wire clr_seq = rd_data & stat_seen_r;
  wire wake_addr = mute_request & ctrl1_r[`ASR_C1_WAKE] & evt_frame &
    addr_msb;
  wire wake_idle = mute_request & ~ctrl1_r[`ASR_C1_WAKE] & evt_idle;
  wire accept = evt_frame & (~mute_request | wake_addr);
  wire idle_set = evt_idle & ~mute_request & ~idle_r;
  // Flags and registers; a flag set wins over a clear, but a wake clear of RWU wins over a write
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl1_r <= `ASR_RESET_BYTE;
      ctrl2_r <= `ASR_RESET_BYTE;
      baud_r <= `ASR_RESET_BYTE;
      rx_fine_r <= `ASR_RESET_BYTE;
      tx_fine_r <= `ASR_RESET_BYTE;
      receive_buffer_r <= 9'h000;
      receive_full_flag_r <= 1'b0;
      noise_flag_r <= 1'b0;
      framing_fault_flag_r <= 1'b0;
      parity_fail_flag_r <= 1'b0;
      overrun_r <= 1'b0;
      idle_r <= 1'b0;
      stat_seen_r <= 1'b0;
      hidden_noise_r <= 1'b0;
    end else begin
      if (rd_stat) stat_seen_r <= 1'b1;
      else if (rd_data) stat_seen_r <= 1'b0;
      if (wr_go) begin
        case (avs_address)
          `ASR_OFF_CTRL1: ctrl1_r <= avs_writedata[7:0];
          `ASR_OFF_CTRL2: ctrl2_r <= avs_writedata[7:0];
          `ASR_OFF_BAUD: baud_r <= avs_writedata[7:0];
          `ASR_OFF_RXFINE: rx_fine_r <= avs_writedata[7:0];
          `ASR_OFF_TXFINE: tx_fine_r <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (wake_addr | wake_idle) ctrl2_r[`ASR_C2_RWU] <= 1'b0;
      if (clr_seq) begin
        receive_full_flag_r <= 1'b0;
        noise_flag_r <= 1'b0;
        framing_fault_flag_r <= 1'b0;
        parity_fail_flag_r <= 1'b0;
        overrun_r <= 1'b0;
        idle_r <= 1'b0;
      end
      if (idle_set) idle_r <= 1'b1;
      if (accept) begin
        if (receive_full_flag_r && !clr_seq) begin
          overrun_r <= 1'b1;
        end else begin
          receive_buffer_r <= word;
          receive_full_flag_r <= 1'b1;
          noise_flag_r <= frame_nf | hidden_noise_r;
          framing_fault_flag_r <= frame_fe;
          parity_fail_flag_r <= rx_par_bad;
          hidden_noise_r <= 1'b0;
        end
      end else if (evt_frame) begin
        hidden_noise_r <= hidden_noise_r | frame_nf;
      end
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    avs_readdata = 32'h00000000;
    case (avs_address)
      `ASR_OFF_STATUS: avs_readdata[5:0] = {receive_full_flag_r, idle_r,
        overrun_r, noise_flag_r, framing_fault_flag_r, parity_fail_flag_r};
      `ASR_OFF_DATA: avs_readdata[8:0] = receive_buffer_r;
      `ASR_OFF_CTRL1: avs_readdata[7:0] = ctrl1_r;
      `ASR_OFF_CTRL2: avs_readdata[7:0] = ctrl2_r;
      `ASR_OFF_BAUD: avs_readdata[7:0] = baud_r;
      `ASR_OFF_RXFINE: avs_readdata[7:0] = rx_fine_r;
      `ASR_OFF_TXFINE: avs_readdata[7:0] = tx_fine_r;
      default: avs_readdata = 32'h00000000;
    endcase
  end

  // Interrupt: receive full or overrun, idle, parity, never while muted
  assign rx_irq = ~mute_request & (
    (ctrl2_r[`ASR_C2_RIE] & (receive_full_flag_r | overrun_r)) |
    (ctrl2_r[`ASR_C2_ILIE] & idle_r) |
    (ctrl1_r[`ASR_C1_PIE] & parity_fail_flag_r));
endmodule // asr_top

// ===== asr_map.vh
// Constants for the async serial receive checker, baud and mute block.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
`define ASR_OFF_STATUS 4'h0
`define ASR_OFF_DATA 4'h1
`define ASR_OFF_CTRL1 4'h2
`define ASR_OFF_CTRL2 4'h3
`define ASR_OFF_BAUD 4'h4
`define ASR_OFF_RXFINE 4'h5
`define ASR_OFF_TXFINE 4'h6
`define ASR_ST_PE 0
`define ASR_ST_FE 1
`define ASR_ST_NF 2
`define ASR_ST_OR 3
`define ASR_ST_IDLE 4
`define ASR_ST_RECEIVE_FULL_FLAG 5
`define ASR_C1_M 4
`define ASR_C1_WAKE 3
`define ASR_C1_PCE 2
`define ASR_C1_PS 1
`define ASR_C1_PIE 0
`define ASR_C2_RIE 5
`define ASR_C2_ILIE 4
`define ASR_C2_TE 3
`define ASR_C2_RE 2
`define ASR_C2_RWU 1
`define ASR_OVERSAMPLE 16
`define ASR_RESET_BYTE 8'h00
`endif

// ===== asr_chk_assertions.sv
// Port checks on asr_top: wait state, reset, tx parity, rx flags.
// Bound to asr_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module asr_chk (
  input wire clk, // Clock
  input wire rstn, // Reset, active low
  input wire [3:0] avs_address, // Word index
  input wire avs_read, // Read
  input wire avs_write, // Write
  input wire [31:0] avs_writedata, // Write data
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire [8:0] tx_word, // Tx word
  input wire [8:0] tx_shift_word, // Tx word with parity
  input wire rx_irq // Interrupt
);
  reg [4:0] c1_r; // Control one copy
  wire req = avs_read | avs_write;
  wire st_rd = avs_read & !avs_waitrequest & (avs_address == 4'h0);
  // Copy control one on each accepted write
  always @(posedge clk) begin
    if (!rstn) c1_r <= 5'h00;
    else if (avs_write & !avs_waitrequest & (avs_address == 4'h2))
      c1_r <= avs_writedata[4:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req_start;
    req && !$past(req);
  endsequence
  property p_wait;
    s_req_start |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not one cycle");
  property p_rst;
    $rose(rstn) |-> !rx_irq && !avs_waitrequest;
  endproperty
  a_rst: assert property (p_rst) else $error("dirty reset");
  property p_par7;
    c1_r[2] && !c1_r[4] |-> tx_shift_word[7] == (^tx_word[6:0] ^ c1_r[1]);
  endproperty
  a_par7: assert property (p_par7) else $error("bad parity 7");
  property p_par8;
    c1_r[2] && c1_r[4] |-> tx_shift_word[8] == (^tx_word[7:0] ^ c1_r[1]);
  endproperty
  a_par8: assert property (p_par8) else $error("bad parity 8");
  property p_raw;
    !c1_r[2] |-> tx_shift_word == tx_word;
  endproperty
  a_raw: assert property (p_raw) else $error("word altered");
  property p_nf;
    st_rd && avs_readdata[2] |-> avs_readdata[5];
  endproperty
  a_nf: assert property (p_nf) else $error("noise without full");
  property p_fe;
    st_rd && avs_readdata[1] |-> avs_readdata[5];
  endproperty
  a_fe: assert property (p_fe) else $error("framing without full");
  property p_pe;
    st_rd && avs_readdata[0] && c1_r[0] |-> rx_irq;
  endproperty
  a_pe: assert property (p_pe) else $error("parity irq missing");
endmodule // asr_chk
bind asr_top asr_chk chk (.clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_word(tx_word), .tx_shift_word(tx_shift_word), .rx_irq(rx_irq));

// ===== asr_peer.sv
// Remote serial transmitter driving the receive pin.
// Assumes bit_cycles clocks per bit, set to the receiver's rate.
`timescale 1ns/1ps
module asr_peer (
  input wire clk, // Core clock
  output reg line // Serial line, idle high
);
  integer bit_cycles = 16;
  integer b;
  integer c;
  reg v;
  initial line = 1'b1;
  // Start low, data lsb first, stop; bit g gets a two-clock glitch
  // that outlives the input filter and spoils one centre sample
  task send(input [8:0] w, input integer n, input stop_v, input integer g);
    begin
      for (b = 0; b < n + 2; b = b + 1) begin
        v = (b == 0) ? 1'b0 : (b > n) ? stop_v : w[b-1];
        for (c = 0; c < bit_cycles; c = c + 1) begin
          line <= (b == g && (c == 16 || c == 17)) ? ~v : v;
          @(posedge clk);
        end
      end
      line <= 1'b1;
      repeat (3 * bit_cycles) @(posedge clk);
    end
  endtask
  // Start pulse that ends before the centre samples
  task false_start;
    begin
      line <= 1'b0;
      repeat (8) @(posedge clk);
      line <= 1'b1;
      repeat (3 * bit_cycles) @(posedge clk);
    end
  endtask
endmodule // asr_peer

// ===== testbench.sv
// Self-checking bench for the serial receive, baud and parity block.
// Assumes asr_top on Avalon-MM and the asr_peer line model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [8:0] tx_word = 9'h000;
  reg [8:0] b;
  reg [63:0] m;
  reg [63:0] exp_q[$];
  wire [31:0] avs_readdata;
  wire [8:0] tx_shift_word;
  wire avs_waitrequest, ser, tx_tick, rx_irq;
  integer bad_count = 0, samples_checked = 0, seed = 59738, i, t;
  integer pf [0:3] = '{1, 3, 4, 13};
  always #5 clk = ~clk;
  asr_peer pm (.clk(clk), .line(ser));
  asr_top dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_input_pin(ser), .tx_word(tx_word),
    .tx_shift_word(tx_shift_word), .tx_tick(tx_tick), .rx_irq(rx_irq));
  // One access, held until waitrequest is low at an edge
  task acc(input wr, input [3:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      tx_word <= $random(seed);
      do @(negedge clk); while (avs_waitrequest !== 1'b0);
      @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  // A read notes its masked expectation before it starts
  task rd(input [3:0] a, input [31:0] mk, input [31:0] v);
    begin
      exp_q.push_back({mk, v & mk});
      acc(1'b0, a, 32'h0);
    end
  endtask
  // Compares each accepted read with the oldest note
  always @(negedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      m = exp_q.pop_front();
      `CHK("readdata", m[31:0], avs_readdata & m[63:32])
    end
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i++) rd(i[3:0], 32'hFFFFFFFF, 32'h0);
    acc(1'b1, 4'hF, 32'hFF);
    rd(4'hF, 32'hFFFFFFFF, 32'h0);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      acc(1'b1, 4'h4, {i[1:0], i[2:0], 3'h0});
      acc(1'b1, 4'h6, i);
      do @(negedge clk); while (tx_tick !== 1'b1);
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (tx_tick !== 1'b1 && t < 999);
      `CHK("tick", pf[i] * (1 << i) * (i ? i : 1), t)
      @(posedge clk);
    end
    // Rx tick every second clock, so one sample spans two clocks
    acc(1'b1, 4'h4, 32'h1);
    acc(1'b1, 4'h6, 32'h0);
    pm.bit_cycles = 32;
    $display("test baud done");
    acc(1'b1, 4'h3, 32'h24);
    b = $random(seed);
    pm.send(b, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h20);
    rd(1, 32'hFF, b);
    rd(0, 32'h3F, 32'h0);
    pm.send(b, 8, 1'b1, 4);
    rd(0, 32'h3F, 32'h24);
    rd(1, 32'hFF, b);
    rd(0, 32'h3F, 32'h0);
    pm.false_start;
    rd(0, 32'h3F, 32'h0);
    pm.send(b, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h24);
    rd(1, 32'hFF, b);
    pm.send(9'h000, 8, 1'b0, 99);
    rd(0, 32'h3F, 32'h22);
    rd(1, 32'hFF, 32'h0);
    pm.send(b, 8, 1'b1, 99);
    pm.send({1'b0, ~b[7:0]}, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h28);
    rd(1, 32'hFF, b);
    $display("test receive done");
    acc(1'b1, 4'h3, 32'h04);
    acc(1'b1, 4'h2, 32'h05);
    pm.send({1'b0, ~^b[6:0], b[6:0]}, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h21);
    rd(1, 32'h7F, b);
    acc(1'b1, 4'h2, 32'h07);
    pm.send({1'b0, ~^b[6:0], b[6:0]}, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h20);
    rd(1, 32'h7F, b);
    acc(1'b1, 4'h2, 32'h15);
    pm.send({^b[7:0], b[7:0]}, 9, 1'b1, 99);
    rd(0, 32'h3F, 32'h20);
    rd(1, 32'hFF, b);
    $display("test parity done");
    acc(1'b1, 4'h2, 32'h08);
    acc(1'b1, 4'h3, 32'h06);
    pm.send({2'h0, b[6:0]}, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h0);
    pm.send({2'h1, b[6:0]}, 8, 1'b1, 99);
    rd(0, 32'h3F, 32'h20);
    rd(1, 32'hFF, {1'b1, b[6:0]});
    rd(3, 32'h3F, 32'h04);
    acc(1'b1, 4'h2, 32'h00);
    acc(1'b1, 4'h3, 32'h06);
    pm.send(9'h0FF, 8, 1'b1, 99);
    repeat (200) @(posedge clk);
    rd(3, 32'h3F, 32'h04);
    rd(0, 32'h3F, 32'h0);
    $display("test mute done");
    end_sim;
  end
endmodule // testbench
